// File: rtl/cds_sequencer.sv
// power-up direction sequencer for a bidirectional resonant charger
`timescale 1ns/1ps
`include "cds_consts.svh"

module cds_sequencer #(
  parameter int VW = 10,
  parameter int DW = 8,
  parameter int FRAME_BITS = 16,
  parameter int unsigned HOLD_CYCLES =
    `CDS_HOLD_MS * (`CDS_NS_PER_MS / `CDS_CLK_NS) + 1,
  parameter int unsigned SAMPLE_CYCLES =
    `CDS_SAMPLE_US * (`CDS_NS_PER_US / `CDS_CLK_NS),
  parameter int unsigned DEBOUNCE_CYCLES =
    `CDS_DEBOUNCE_US * (`CDS_NS_PER_US / `CDS_CLK_NS)
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [VW-1:0] battery_voltage_measure_in,
  input wire logic adc_data_in,
  output logic adc_select_n_out,
  output logic adc_clock_out,
  input wire logic mode_key_in,
  input wire logic plus_key_in,
  input wire logic minus_key_in,
  input wire logic fault_force_in,
  input wire logic fault_line_n_in,
  output logic fault_line_n_out,
  output logic fault_line_n_oe_out,
  output logic fault_active_out,
  output logic converter_hold_out,
  output logic power_flow_direction_out,
  output logic constant_voltage_mode_out,
  output logic current_setpoint_pwm_out,
  output logic voltage_setpoint_pwm_out
);
  localparam int BW = $clog2(FRAME_BITS + 1);
  localparam int unsigned SCLK_HALF =
    (`CDS_SCLK_HALF_NS + `CDS_CLK_NS - 1) / `CDS_CLK_NS;

  cds_pkg::cds_state_t state;
  logic [31:0] tmr, up_cnt;
  logic [15:0] div;
  logic [BW-1:0] bits;
  logic [FRAME_BITS-1:0] shift;
  logic [VW-1:0] bat_q;
  logic [DW-1:0] cc_mem, cv_mem, pwm_cnt;
  logic sdo_m, sdo_s, fault_m, fault_s;
  logic [2:0] key_m, key_s, key_st, key_press;

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk_in) begin
    sdo_m <= adc_data_in;
    sdo_s <= sdo_m;
    fault_m <= fault_line_n_in;
    fault_s <= fault_m;
  end

  // key debounce: a press is the settled rising level
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_key
      logic [31:0] kcnt;
      wire raw = (gi == `CDS_KEY_MODE) ? mode_key_in :
                 (gi == `CDS_KEY_PLUS) ? plus_key_in : minus_key_in;
      always_ff @(posedge sys_clk_in) begin
        key_m[gi] <= raw;
        key_s[gi] <= key_m[gi];
        if (sys_rst_in) begin
          key_st[gi] <= 1'b0;
          key_press[gi] <= 1'b0;
          kcnt <= 32'h0000_0000;
        end else begin
          key_press[gi] <= 1'b0;
          if (key_s[gi] == key_st[gi]) begin
            kcnt <= 32'h0000_0000;
          end else if (kcnt >= DEBOUNCE_CYCLES - 1) begin
            key_st[gi] <= key_s[gi];
            key_press[gi] <= key_s[gi];
            kcnt <= 32'h0000_0000;
          end else begin
            kcnt <= kcnt + 32'h0000_0001;
          end
        end
      end
    end
  endgenerate

  // voltage windows; equal-to-limit readings fall to sample again
  wire [VW-1:0] bus_v = shift[VW-1:0];
  wire bus_mid = bus_v > `CDS_BUS_LO_V && bus_v < `CDS_BUS_HI_V;
  wire bus_low = bus_v < `CDS_BUS_LO_V;
  wire bat_low = bat_q < `CDS_BAT_LO_V;
  wire bat_mid = bat_q > `CDS_BAT_LO_V && bat_q < `CDS_BAT_HI_V;
  wire g2b_ok = bus_mid && bat_low;
  wire b2g_ok = bus_low && bat_mid;
  wire tmr_end = tmr >= SAMPLE_CYCLES - 1;
  wire div_end = div >= 16'(SCLK_HALF - 1);
  wire frame_end = bits == BW'(FRAME_BITS);
  wire is_g2b = state == cds_pkg::CDS_ST_G2B;
  wire is_b2g = state == cds_pkg::CDS_ST_B2G;
  wire running = is_g2b || is_b2g;
  wire up_done = up_cnt >= HOLD_CYCLES;

  // sequence: wait, read bus ADC frame, decide, then run for good
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state <= cds_pkg::CDS_ST_WAIT;
      tmr <= 32'h0000_0000;
      div <= 16'h0000;
      bits <= '0;
      shift <= '0;
      bat_q <= '0;
      adc_select_n_out <= 1'b1;
      adc_clock_out <= 1'b0;
      power_flow_direction_out <= 1'b0;
    end else begin
      case (state)
        cds_pkg::CDS_ST_WAIT: begin
          if (tmr_end) begin
            tmr <= 32'h0000_0000;
            adc_select_n_out <= 1'b0;
            state <= cds_pkg::CDS_ST_CONVERT;
          end else begin
            tmr <= tmr + 32'h0000_0001;
          end
        end
        cds_pkg::CDS_ST_CONVERT: begin
          if (!div_end) begin
            div <= div + 16'h0001;
          end else begin
            div <= 16'h0000;
            if (!adc_clock_out) begin
              // data is stable mid-bit, so rising edge sampling is safe
              adc_clock_out <= 1'b1;
              shift <= {shift[FRAME_BITS-2:0], sdo_s};
              bits <= bits + 1'b1;
            end else begin
              adc_clock_out <= 1'b0;
              if (frame_end) begin
                adc_select_n_out <= 1'b1;
                bat_q <= battery_voltage_measure_in;
                state <= cds_pkg::CDS_ST_DECIDE;
              end
            end
          end
        end
        cds_pkg::CDS_ST_DECIDE: begin
          bits <= '0;
          if (g2b_ok) begin
            power_flow_direction_out <= 1'b1;
            state <= cds_pkg::CDS_ST_G2B;
          end else if (b2g_ok) begin
            power_flow_direction_out <= 1'b0;
            state <= cds_pkg::CDS_ST_B2G;
          end else begin
            state <= cds_pkg::CDS_ST_WAIT;
          end
        end
        cds_pkg::CDS_ST_G2B: state <= state;
        cds_pkg::CDS_ST_B2G: bat_q <= battery_voltage_measure_in; // tracked
        default: state <= cds_pkg::CDS_ST_WAIT;
      endcase
    end
  end
  select_frame_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) state == cds_pkg::CDS_ST_WAIT && tmr_end
    |=> !adc_select_n_out && state == cds_pkg::CDS_ST_CONVERT)
    else $error("select not asserted for frame");
  clock_idle_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) adc_select_n_out |-> !adc_clock_out)
    else $error("serial clock toggles while deselected");
  dir_charge_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) state == cds_pkg::CDS_ST_DECIDE && g2b_ok
    |=> power_flow_direction_out && is_g2b) else $error("charge missed");
  dir_discharge_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) state == cds_pkg::CDS_ST_DECIDE && b2g_ok
    |=> !power_flow_direction_out && is_b2g) else $error("discharge missed");
  window_resample_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) state == cds_pkg::CDS_ST_DECIDE && !g2b_ok
    && !b2g_ok |=> state == cds_pkg::CDS_ST_WAIT && tmr == 32'h0000_0000)
    else $error("no resample on invalid window");
  dir_kept_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) running |=> running
    && $stable(power_flow_direction_out)) else $error("direction changed");

  // power-on timer saturates so it never wraps back below the limit
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      up_cnt <= 32'h0000_0000;
    end else if (!up_done) begin
      up_cnt <= up_cnt + 32'h0000_0001;
    end
  end

  // hold release: running, past the power-on delay, no fault present
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      converter_hold_out <= 1'b0;
    end else begin
      converter_hold_out <= running && up_done && fault_s;
    end
  end
  hold_idle_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !running |-> !converter_hold_out)
    else $error("hold high before run");
  hold_delay_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) $rose(converter_hold_out)
    |-> $past(up_cnt) >= HOLD_CYCLES && $past(fault_s))
    else $error("hold released early");
  fault_mute_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) !fault_s |=> !converter_hold_out)
    else $error("hold stays high during fault");

  // fault pin driver; enable is low while pulling the line down
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      fault_line_n_out <= 1'b0;
      fault_line_n_oe_out <= 1'b1;
      fault_active_out <= 1'b0;
    end else begin
      fault_line_n_out <= 1'b0;
      fault_line_n_oe_out <= ~fault_force_in;
      fault_active_out <= ~fault_s;
    end
  end

  // retained setpoints and mode, adjusted only while charging
  wire cv_sel = constant_voltage_mode_out;
  wire k_plus = key_press[`CDS_KEY_PLUS] && !key_press[`CDS_KEY_MINUS];
  wire k_minus = key_press[`CDS_KEY_MINUS] && !key_press[`CDS_KEY_PLUS];
  wire [DW-1:0] cc_up = (cc_mem >= `CDS_CC_DUTY_MAX - `CDS_DUTY_STEP) ?
    `CDS_CC_DUTY_MAX : cc_mem + `CDS_DUTY_STEP;
  wire [DW-1:0] cv_up = (cv_mem >= `CDS_CV_DUTY_MAX - `CDS_DUTY_STEP) ?
    `CDS_CV_DUTY_MAX : cv_mem + `CDS_DUTY_STEP;
  wire [DW-1:0] cc_dn = (cc_mem <= `CDS_DUTY_MIN + `CDS_DUTY_STEP) ?
    `CDS_DUTY_MIN : cc_mem - `CDS_DUTY_STEP;
  wire [DW-1:0] cv_dn = (cv_mem <= `CDS_DUTY_MIN + `CDS_DUTY_STEP) ?
    `CDS_DUTY_MIN : cv_mem - `CDS_DUTY_STEP;
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cc_mem <= `CDS_CC_DUTY_RST;
      cv_mem <= `CDS_CV_DUTY_RST;
      constant_voltage_mode_out <= 1'b1;
    end else if (is_g2b) begin
      if (key_press[`CDS_KEY_MODE]) begin
        constant_voltage_mode_out <= ~cv_sel;
      end
      if (k_plus && cv_sel) cv_mem <= cv_up;
      if (k_plus && !cv_sel) cc_mem <= cc_up;
      if (k_minus && cv_sel) cv_mem <= cv_dn;
      if (k_minus && !cv_sel) cc_mem <= cc_dn;
    end
  end
  mode_toggle_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) is_g2b && key_press[`CDS_KEY_MODE]
    |=> $changed(constant_voltage_mode_out)) else $error("mode not toggled");
  cc_limit_a: assert property (@(posedge sys_clk_in)
    disable iff (sys_rst_in) cc_mem <= `CDS_CC_DUTY_MAX)
    else $error("current duty above limit");

  // setpoint duties; discharge scales battery by 3/8 onto the duty curve
  wire [11:0] b2g_full = 12'(bat_q) * `CDS_B2G_MUL;
  wire [11:0] b2g_scl = b2g_full >> `CDS_B2G_SHIFT;
  wire [DW-1:0] b2g_duty = (b2g_scl > 12'(`CDS_CV_DUTY_MAX)) ?
    `CDS_CV_DUTY_MAX : b2g_scl[DW-1:0];
  wire [DW-1:0] cc_duty = running ? cc_mem : `CDS_DUTY_MIN;
  wire [DW-1:0] cv_duty = is_b2g ? b2g_duty :
    (is_g2b ? cv_mem : `CDS_DUTY_MIN);
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      pwm_cnt <= '0;
      current_setpoint_pwm_out <= 1'b0;
      voltage_setpoint_pwm_out <= 1'b0;
    end else begin
      pwm_cnt <= pwm_cnt + 1'b1;
      current_setpoint_pwm_out <= pwm_cnt < cc_duty;
      voltage_setpoint_pwm_out <= pwm_cnt < cv_duty;
    end
  end

endmodule : cds_sequencer

// File: rtl/cds_consts.svh
// timing, threshold and duty constants of the charger direction sequencer
`ifndef CDS_CONSTS_SVH
`define CDS_CONSTS_SVH
`define CDS_CLK_NS 32'h0000_0005
`define CDS_NS_PER_MS 32'h000F_4240
`define CDS_NS_PER_US 32'h0000_03E8
`define CDS_HOLD_MS 32'h0000_0BB8
`define CDS_SAMPLE_US 32'h0000_03E8
`define CDS_DEBOUNCE_US 32'h0000_2710
`define CDS_SCLK_HALF_NS 32'h0000_00FA
`define CDS_BUS_LO_V 10'h15E
`define CDS_BUS_HI_V 10'h2EE
`define CDS_BAT_LO_V 10'h0FA
`define CDS_BAT_HI_V 10'h1C2
`define CDS_CC_DUTY_MAX 8'hE6
`define CDS_CV_DUTY_MAX 8'hFF
`define CDS_DUTY_MIN 8'h00
`define CDS_DUTY_STEP 8'h01
`define CDS_CC_DUTY_RST 8'h40
`define CDS_CV_DUTY_RST 8'h80
`define CDS_B2G_MUL 12'h003
`define CDS_B2G_SHIFT 3
`define CDS_KEY_MODE 0
`define CDS_KEY_PLUS 1
`define CDS_KEY_MINUS 2
`endif

// File: rtl/cds_pkg.sv
// types shared by the charger direction sequencer
package cds_pkg;
  typedef enum logic [2:0] {
    CDS_ST_WAIT = 3'b000,
    CDS_ST_CONVERT = 3'b001,
    CDS_ST_DECIDE = 3'b010,
    CDS_ST_G2B = 3'b011,
    CDS_ST_B2G = 3'b100
  } cds_state_t;
endpackage : cds_pkg

// File: tb/cds_adc_model.sv
// behavioural bus-voltage serial converter on the power stage side
`timescale 1ns/1ps
module cds_adc_model (
  input wire logic adc_select_n_in,
  input wire logic adc_clock_in,
  input wire logic [15:0] frame_in,
  output logic adc_data_out
);
  logic [15:0] shift_reg;
  initial adc_data_out = 1'b0;
  // frame is captured as select falls, msb goes out at once
  always @(negedge adc_select_n_in) begin
    shift_reg = frame_in;
    adc_data_out = frame_in[15];
  end
  // next bit after each falling clock, stable long before the rise
  always @(negedge adc_clock_in) begin
    if (!adc_select_n_in) begin
      shift_reg = {shift_reg[14:0], 1'b0};
      adc_data_out = shift_reg[15];
    end
  end
  // released output shows no stale bit, so a late sample is caught
  always @(posedge adc_select_n_in) begin
    adc_data_out = ~adc_data_out;
  end
endmodule : cds_adc_model

// File: tb/charger_direction_sequencer_tb.sv
// self-checking bench for the charger direction sequencer
`timescale 1ns/1ps
module charger_direction_sequencer_tb;
  localparam int HOLD = 2000;
  localparam int DEB = 4;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [9:0] bat = 10'h000;
  logic [15:0] frame = 16'h0000;
  logic mkey = 1'b0, pkey = 1'b0, nkey = 1'b0, force_f = 1'b0, pull_n = 1'b1;
  logic adc_data, sel_n, sclk, f_out, f_oe, f_act, hold, dir, volt_mode;
  logic cur_pwm, vol_pwm;
  logic [15:0] cur_d, vol_d;
  int err_total = 0;
  int n_tests = 0;
  int up = 0;
  // wire level: pulled up unless either party pulls it low
  wire logic fault_wire = (f_oe ? 1'b1 : f_out) & pull_n;
  always #2.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) up <= sys_rst_in ? 0 : up + 1;

  cds_sequencer #(.HOLD_CYCLES(HOLD), .SAMPLE_CYCLES(20),
    .DEBOUNCE_CYCLES(DEB)) cds_sequencer_inst (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .battery_voltage_measure_in(bat), .adc_data_in(adc_data),
    .adc_select_n_out(sel_n), .adc_clock_out(sclk),
    .mode_key_in(mkey), .plus_key_in(pkey), .minus_key_in(nkey),
    .fault_force_in(force_f), .fault_line_n_in(fault_wire),
    .fault_line_n_out(f_out), .fault_line_n_oe_out(f_oe),
    .fault_active_out(f_act), .converter_hold_out(hold),
    .power_flow_direction_out(dir), .constant_voltage_mode_out(volt_mode),
    .current_setpoint_pwm_out(cur_pwm), .voltage_setpoint_pwm_out(vol_pwm));

  cds_adc_model cds_adc_model_inst (.adc_select_n_in(sel_n),
    .adc_clock_in(sclk), .frame_in(frame), .adc_data_out(adc_data));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick

  task automatic do_reset();
    sys_rst_in = 1'b1;
    tick(8);
    sys_rst_in = 1'b0;
  endtask : do_reset

  // bounded wait for a select level; a hang ends the run
  task automatic wait_sel(input logic want);
    int i;
    for (i = 0; i < 5000 && sel_n !== want; i++) tick(1);
    if (i == 5000) begin
      err_total++;
      stop_test();
    end
  endtask : wait_sel

  task automatic wait_frame();
    wait_sel(1'b0);
    wait_sel(1'b1);
    tick(4);
  endtask : wait_frame

  // high count over one full 256-clock period equals the duty
  task automatic duty();
    cur_d = 16'h0000;
    vol_d = 16'h0000;
    repeat (256) begin
      tick(1);
      cur_d = cur_d + {15'h0000, cur_pwm};
      vol_d = vol_d + {15'h0000, vol_pwm};
    end
  endtask : duty

  task automatic press(input int k);
    mkey = (k == 0);
    pkey = (k == 1 || k == 3);
    nkey = (k == 2 || k == 3);
    tick(DEB + 10);
    {mkey, pkey, nkey} = 3'b000;
    tick(10);
  endtask : press

  logic [9:0] bus_tab [5] = '{10'd350, 10'd800, 10'd500, 10'd300, 10'd100};
  logic [9:0] bat_tab [5] = '{10'd100, 10'd100, 10'd300, 10'd250, 10'd100};

  initial begin
    do_reset();
    // five non-matching pairs, both low-limit edges included, must resample
    for (int i = 0; i < 5; i++) begin
      frame = {6'h2D, bus_tab[i]};
      bat = bat_tab[i];
      wait_frame();
      check(hold, 1'b0);
      check(dir, 1'b0);
    end
    frame = {6'h2D, 10'd749};
    bat = 10'd249;
    wait_frame();
    check(dir, 1'b1);
    tick(6);
    check(hold, 1'b1);
    check(volt_mode, 1'b1);
    duty();
    check(cur_d, 16'd64);
    check(vol_d, 16'd128);
    press(0);
    check(volt_mode, 1'b0);
    press(1);
    duty();
    check(cur_d, 16'd65);
    check(vol_d, 16'd128);
    press(0);
    check(volt_mode, 1'b1);
    press(2);
    duty();
    check(vol_d, 16'd127);
    check(cur_d, 16'd65);
    // plus and minus together must leave both duties alone
    press(3);
    duty();
    check(vol_d, 16'd127);
    check(cur_d, 16'd65);
    press(0);
    repeat (170) press(1);
    duty();
    check(cur_d, 16'd230);
    frame = {6'h2D, 10'd300};
    bat = 10'd400;
    tick(100);
    check(dir, 1'b1);
    check(sel_n, 1'b1);
    // far side pulls the shared fault wire, then the device does
    pull_n = 1'b0;
    tick(6);
    check(f_act, 1'b1);
    check(hold, 1'b0);
    pull_n = 1'b1;
    tick(6);
    check(hold, 1'b1);
    force_f = 1'b1;
    tick(2);
    check(fault_wire, 1'b0);
    check({f_oe, f_out}, 2'b00);
    tick(6);
    check(f_act, 1'b1);
    check(hold, 1'b0);
    force_f = 1'b0;
    // second power-up chooses battery-to-grid
    do_reset();
    check({sel_n, sclk, hold, volt_mode}, 4'b1001);
    wait_frame();
    check(dir, 1'b0);
    check(hold, 1'b0);
    for (int i = 0; i < 1000 && hold !== 1'b1; i++) tick(1);
    check({15'h0000, up >= HOLD}, 16'h0001);
    check(hold, 1'b1);
    duty();
    check(vol_d, 16'd150);
    check(cur_d, 16'd64);
    press(0);
    check(volt_mode, 1'b1);
    bat = 10'd200;
    tick(4);
    duty();
    check(vol_d, 16'd75);
    stop_test();
  end
endmodule : charger_direction_sequencer_tb
